/* File: design/dru_pkg.sv */
// dru_pkg: constants and types for the ram update port
// assumes: 100 MHz master clock, spi link in its own clock domain
package dru_pkg;

  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W       = 10;
  localparam int unsigned PARAM_DEPTH  = 256;
  localparam int unsigned PARAM_W      = 22;
  localparam int unsigned PROG_DEPTH   = 512;
  localparam int unsigned PROG_W       = 35;
  localparam logic [9:0]  PROG_BASE    = 10'h200;
  localparam logic [9:0]  CTRL1_ADDR   = 10'h100;
  localparam logic [9:0]  CTRL2_ADDR   = 10'h101;
  localparam logic [9:0]  SAFE_BASE    = 10'h102;
  localparam int unsigned SAFE_NUM     = 5;

  // ------------------------------------------------------------
  // control fields and reset values
  // ------------------------------------------------------------
  localparam int unsigned CTRL1_W       = 14;
  localparam int unsigned CTRL2_W       = 10;
  localparam int unsigned SHUTDOWN_BIT  = 10;
  localparam int unsigned SAFE_GO_BIT   = 12;
  localparam int unsigned RAMP_FAST_BIT = 9;
  localparam int unsigned STAT_SAFE_BIT = 0;
  localparam int unsigned STAT_HALT_BIT = 1;
  localparam logic [13:0] CTRL1_RST     = 14'h0000;
  localparam logic [9:0]  CTRL2_RST     = 10'h200;
  localparam int unsigned SAFE_LOC_LSB  = 24;

  // ------------------------------------------------------------
  // frame layout, in bits on the wire
  // ------------------------------------------------------------
  localparam int unsigned HDR_BITS     = 16;
  localparam int unsigned DIR_BIT      = 10;
  localparam logic [5:0]  PARAM_BITS   = 6'd24;
  localparam logic [5:0]  PROG_BITS    = 6'd40;
  localparam logic [5:0]  CTRL_WR_BITS = 6'd16;
  localparam logic [5:0]  CTRL_RD_BITS = 6'd8;
  localparam logic [5:0]  SAFE_BITS    = 6'd32;
  localparam logic [5:0]  RD_LOAD_BIT  = 6'd1;
  localparam int unsigned WORD_MAX     = 40;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned BOOT_CYCLES      = 1024;
  localparam int unsigned FREE_CYCLES      = 5;
  localparam int unsigned RAMP_MIN_MS      = 10;
  localparam int unsigned RAMP_MAX_MS      = 20;
  localparam int unsigned RAMP_TIME_MS     = (RAMP_MIN_MS + RAMP_MAX_MS) / 2;
  localparam int unsigned RAMP_CYCLES      = RAMP_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned GAIN_STEPS       = 256;
  localparam int unsigned RAMP_STEP_CYCLES = RAMP_CYCLES / GAIN_STEPS;
  localparam int unsigned SLOW_FACTOR      = 4;
  localparam logic [7:0]  GAIN_MAX         = 8'hFF;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SD_RUN, SD_RAMP_DOWN, SD_HALTED, SD_RAMP_UP} dru_sd_state_t;
  typedef enum logic {PH_HDR, PH_DATA} dru_phase_t;

endpackage : dru_pkg

/* File: design/dru_port.sv */
// dru_port: spi access port to the parameter and program rams of the core
// assumes: host drives spi mode 0 frames, core supplies ram read addresses,
// a param busy flag and a frame start pulse on sys_clk
`timescale 1ns/1ps

module dru_port
  import dru_pkg::*;
#(
  parameter int unsigned RAMP_STEP = RAMP_STEP_CYCLES
) (
  // system
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // spi link
  input  wire logic                 spi_clk,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_mosi,
  output logic                      spi_miso,
  output logic                      spi_miso_oe_n,
  // core ram ports
  input  wire logic [7:0]           core_param_addr,
  input  wire logic                 core_param_busy,
  input  wire logic [8:0]           core_prog_addr,
  input  wire logic                 core_frame_start,
  output logic [PARAM_W-1:0]        core_param_rdata,
  output logic [PROG_W-1:0]         core_prog_rdata,
  // core control and status
  output logic                      core_halt,
  output logic [7:0]                volume_gain,
  output logic                      boot_busy,
  output logic [CTRL1_W-1:0]        ctrl1_bits,
  output logic [CTRL2_W-1:0]        ctrl2_bits
);

  // ------------------------------------------------------------
  // spi side: frame state
  // ------------------------------------------------------------
  logic [5:0]          bit_cnt_reg;
  dru_phase_t          phase_reg;
  logic [39:0]         rx_shift_reg;
  logic [39:0]         tx_reg;
  logic [9:0]          addr_reg;
  logic                dir_rd_reg;
  logic [5:0]          word_bits_reg;
  logic                miso_reg;
  logic                miso_oe_n_reg;
  // spi side: words handed to the system side
  logic                wr_tgl_reg;
  logic [9:0]          wr_addr_reg;
  logic [39:0]         wr_data_reg;
  logic                rd_tgl_reg;
  logic [9:0]          rd_addr_reg;
  // system side: read answer, held until the next request
  logic [39:0]         rd_word_reg;

  wire [39:0] rx_shift_next = {rx_shift_reg[38:0], spi_mosi};
  wire [9:0]  hdr_addr      = rx_shift_next[9:0];
  wire        hdr_rd        = rx_shift_next[DIR_BIT];
  wire        hdr_is_safe   = (hdr_addr >= SAFE_BASE) &&
                              (hdr_addr < SAFE_BASE + 10'(SAFE_NUM));

  // bit count from the address, and for ctrl1 also from the direction
  wire [5:0]  hdr_bits = (hdr_addr >= PROG_BASE)       ? PROG_BITS :
                         (hdr_addr < 10'(PARAM_DEPTH)) ? PARAM_BITS :
                         (hdr_addr == CTRL1_ADDR)      ? (hdr_rd ? CTRL_RD_BITS
                                                                 : CTRL_WR_BITS) :
                         (hdr_addr == CTRL2_ADDR)      ? CTRL_WR_BITS :
                         hdr_is_safe                   ? SAFE_BITS :
                                                         PARAM_BITS;

  wire        hdr_done  = (phase_reg == PH_HDR) && (bit_cnt_reg == 6'(HDR_BITS - 1));
  wire        word_done = (phase_reg == PH_DATA) && (bit_cnt_reg == word_bits_reg - 6'd1);
  wire        rd_load   = (phase_reg == PH_DATA) && dir_rd_reg && (bit_cnt_reg == RD_LOAD_BIT);
  wire [9:0]  addr_inc  = addr_reg + 10'd1;
  wire        pre_ok    = (addr_inc != CTRL1_ADDR);
  wire [5:0]  align_sh  = 6'(WORD_MAX + 2) - word_bits_reg;
  wire [39:0] rd_align  = 40'(rd_word_reg << align_sh);

  // ------------------------------------------------------------
  // spi side: receive and transmit shifting
  // ------------------------------------------------------------
  always_ff @(posedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_reg   <= 6'h00;
      phase_reg     <= PH_HDR;
      rx_shift_reg  <= 40'h00_0000_0000;
      tx_reg        <= 40'h00_0000_0000;
      addr_reg      <= 10'h000;
      dir_rd_reg    <= 1'b0;
      word_bits_reg <= PARAM_BITS;
    end else begin
      rx_shift_reg <= rx_shift_next;
      tx_reg       <= rd_load ? rd_align : {tx_reg[38:0], 1'b0};
      if (hdr_done) begin
        phase_reg     <= PH_DATA;
        bit_cnt_reg   <= 6'h00;
        addr_reg      <= hdr_addr;
        dir_rd_reg    <= hdr_rd;
        word_bits_reg <= hdr_bits;
      end else if (word_done) begin
        bit_cnt_reg <= 6'h00;
        addr_reg    <= addr_inc;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 6'd1;
      end
    end
  end

  // drive on the falling edge so the host samples on the rising one
  always_ff @(negedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      miso_reg      <= 1'b0;
      miso_oe_n_reg <= 1'b1;
    end else begin
      miso_reg      <= (phase_reg == PH_DATA) && dir_rd_reg && tx_reg[39];
      miso_oe_n_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // spi side: word hand-off, lives across frames
  // ------------------------------------------------------------
  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_tgl_reg  <= 1'b0;
      wr_addr_reg <= 10'h000;
      wr_data_reg <= 40'h00_0000_0000;
      rd_tgl_reg  <= 1'b0;
      rd_addr_reg <= 10'h000;
    end else if (!spi_cs_n) begin
      if (word_done && !dir_rd_reg) begin
        wr_tgl_reg  <= ~wr_tgl_reg;
        wr_addr_reg <= addr_reg;
        wr_data_reg <= rx_shift_next;
      end
      if (hdr_done && hdr_rd) begin
        rd_tgl_reg  <= ~rd_tgl_reg;
        rd_addr_reg <= hdr_addr;
      end else if (rd_load && pre_ok) begin
        rd_tgl_reg  <= ~rd_tgl_reg;
        rd_addr_reg <= addr_inc;
      end
    end
  end

  // ------------------------------------------------------------
  // system side: event synchronisers
  // ------------------------------------------------------------
  logic [2:0] wr_sync_reg;
  logic [2:0] rd_sync_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_sync_reg <= 3'h0;
      rd_sync_reg <= 3'h0;
    end else begin
      wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
      rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
    end
  end

  wire wr_evt = wr_sync_reg[2] ^ wr_sync_reg[1];
  wire rd_evt = rd_sync_reg[2] ^ rd_sync_reg[1];

  // ------------------------------------------------------------
  // system side: decode
  // ------------------------------------------------------------
  logic [10:0]        boot_cnt_reg;
  logic               boot_busy_reg;
  logic [CTRL1_W-1:0] ctrl1_reg;
  logic [CTRL2_W-1:0] ctrl2_reg;
  logic               safe_pend_reg;
  logic               safe_done_reg;
  logic [2:0]         free_cnt_reg;
  logic [7:0]         safe_loc_reg [SAFE_NUM];
  logic [21:0]        safe_val_reg [SAFE_NUM];
  logic [SAFE_NUM-1:0] safe_vld_reg;
  dru_sd_state_t      sd_state_reg;
  dru_sd_state_t      sd_next;

  wire       wr_live     = wr_evt && !boot_busy_reg;
  wire       wr_is_param = wr_addr_reg < 10'(PARAM_DEPTH);
  wire       wr_is_prog  = wr_addr_reg >= PROG_BASE;
  wire       wr_is_ctrl1 = wr_addr_reg == CTRL1_ADDR;
  wire       wr_is_ctrl2 = wr_addr_reg == CTRL2_ADDR;
  wire [9:0] wr_safe_off = wr_addr_reg - SAFE_BASE;
  wire       wr_is_safe  = wr_addr_reg >= SAFE_BASE && wr_safe_off < 10'(SAFE_NUM);
  wire       safe_go     = wr_live && wr_is_ctrl1 && wr_data_reg[SAFE_GO_BIT];
  wire       free_ok     = free_cnt_reg == 3'(FREE_CYCLES);
  wire       safe_commit = safe_pend_reg && !boot_busy_reg &&
                           (free_ok || core_frame_start);
  wire       rd_is_ctrl1 = rd_addr_reg == CTRL1_ADDR;
  wire       shut_req    = ctrl1_reg[SHUTDOWN_BIT];
  wire       ramp_fast   = ctrl2_reg[RAMP_FAST_BIT];

  // ------------------------------------------------------------
  // system side: rams
  // ------------------------------------------------------------
  logic [PARAM_W-1:0] param_ram [PARAM_DEPTH];
  logic [PROG_W-1:0]  prog_ram  [PROG_DEPTH];

  wire [PARAM_W-1:0] rd_param_val = param_ram[rd_addr_reg[7:0]];
  wire [PROG_W-1:0]  rd_prog_val  = prog_ram[rd_addr_reg[8:0]];

  // writes from boot clear, spi words and safe commits
  always_ff @(posedge sys_clk) begin
    if (boot_busy_reg) begin
      if (boot_cnt_reg < 11'(PARAM_DEPTH))
        param_ram[boot_cnt_reg[7:0]] <= '0;
      if (boot_cnt_reg < 11'(PROG_DEPTH))
        prog_ram[boot_cnt_reg[8:0]] <= '0;
    end else begin
      if (wr_evt && wr_is_param)
        param_ram[wr_addr_reg[7:0]] <= wr_data_reg[PARAM_W-1:0];
      if (wr_evt && wr_is_prog)
        prog_ram[wr_addr_reg[8:0]] <= wr_data_reg[PROG_W-1:0];
      for (int i = 0; i < SAFE_NUM; i++) begin
        if (safe_commit && safe_vld_reg[i])
          param_ram[safe_loc_reg[i]] <= safe_val_reg[i];
      end
    end
  end

  // registered read ports
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      core_param_rdata <= '0;
      core_prog_rdata  <= '0;
      rd_word_reg      <= 40'h00_0000_0000;
    end else begin
      core_param_rdata <= param_ram[core_param_addr];
      core_prog_rdata  <= prog_ram[core_prog_addr];
      if (rd_evt) begin
        if (rd_addr_reg >= PROG_BASE)
          rd_word_reg <= 40'(rd_prog_val);
        else if (rd_addr_reg < 10'(PARAM_DEPTH))
          rd_word_reg <= 40'(rd_param_val);
        else if (rd_is_ctrl1)
          rd_word_reg <= 40'({(sd_state_reg == SD_HALTED), safe_done_reg});
        else if (rd_addr_reg == CTRL2_ADDR)
          rd_word_reg <= 40'(ctrl2_reg);
        else
          rd_word_reg <= 40'h00_0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // system side: boot and control registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      boot_cnt_reg  <= 11'h000;
      boot_busy_reg <= 1'b1;
    end else if (boot_busy_reg) begin
      boot_cnt_reg  <= boot_cnt_reg + 11'd1;
      boot_busy_reg <= boot_cnt_reg != 11'(BOOT_CYCLES - 1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl1_reg <= CTRL1_RST;
      ctrl2_reg <= CTRL2_RST;
    end else begin
      if (wr_live && wr_is_ctrl1)
        ctrl1_reg <= wr_data_reg[CTRL1_W-1:0];
      if (wr_live && wr_is_ctrl2)
        ctrl2_reg <= wr_data_reg[CTRL2_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // system side: safe transfer
  // ------------------------------------------------------------
  for (genvar g = 0; g < SAFE_NUM; g++) begin : g_hold
    wire hit = wr_live && wr_is_safe && (wr_safe_off == 10'(g));
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        safe_vld_reg[g] <= 1'b0;
        safe_loc_reg[g] <= 8'h00;
        safe_val_reg[g] <= '0;
      end else if (hit) begin
        safe_vld_reg[g] <= 1'b1;
        safe_loc_reg[g] <= wr_data_reg[SAFE_LOC_LSB +: 8];
        safe_val_reg[g] <= wr_data_reg[PARAM_W-1:0];
      end else if (safe_commit) begin
        safe_vld_reg[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      safe_pend_reg <= 1'b0;
      safe_done_reg <= 1'b0;
      free_cnt_reg  <= 3'h0;
    end else begin
      if (core_param_busy)
        free_cnt_reg <= 3'h0;
      else if (!free_ok)
        free_cnt_reg <= free_cnt_reg + 3'd1;
      if (safe_go)
        safe_pend_reg <= 1'b1;
      else if (safe_commit)
        safe_pend_reg <= 1'b0;
      if (safe_commit)
        safe_done_reg <= 1'b1;
      else if (rd_evt && rd_is_ctrl1)
        safe_done_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // system side: soft shutdown with volume ramps
  // ------------------------------------------------------------
  logic [23:0]   step_cnt_reg;
  logic [7:0]    gain_reg;
  logic          halt_reg;

  wire [23:0] step_lim  = ramp_fast ? 24'(RAMP_STEP - 1)
                                    : 24'(RAMP_STEP * SLOW_FACTOR - 1);
  wire        step_tick = step_cnt_reg >= step_lim;
  wire        ramping   = (sd_state_reg == SD_RAMP_DOWN) || (sd_state_reg == SD_RAMP_UP);

  always_comb begin
    sd_next = sd_state_reg;
    case (sd_state_reg)
      SD_RUN:       if (shut_req) sd_next = SD_RAMP_DOWN;
      SD_RAMP_DOWN: begin
        if (!shut_req) sd_next = SD_RAMP_UP;
        else if (step_tick && gain_reg == 8'h00) sd_next = SD_HALTED;
      end
      SD_HALTED:    if (!shut_req) sd_next = SD_RAMP_UP;
      SD_RAMP_UP: begin
        if (shut_req) sd_next = SD_RAMP_DOWN;
        else if (step_tick && gain_reg == GAIN_MAX) sd_next = SD_RUN;
      end
      default:      sd_next = SD_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sd_state_reg <= SD_RUN;
      step_cnt_reg <= 24'h00_0000;
      gain_reg     <= GAIN_MAX;
      halt_reg     <= 1'b0;
    end else begin
      sd_state_reg <= sd_next;
      halt_reg     <= sd_next == SD_HALTED;
      step_cnt_reg <= (ramping && !step_tick) ? step_cnt_reg + 24'd1 : 24'h00_0000;
      if (step_tick && sd_state_reg == SD_RAMP_DOWN && gain_reg != 8'h00)
        gain_reg <= gain_reg - 8'd1;
      else if (step_tick && sd_state_reg == SD_RAMP_UP && gain_reg != GAIN_MAX)
        gain_reg <= gain_reg + 8'd1;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign spi_miso      = miso_reg;
  assign spi_miso_oe_n = miso_oe_n_reg;
  assign core_halt     = halt_reg;
  assign volume_gain   = gain_reg;
  assign boot_busy     = boot_busy_reg;
  assign ctrl1_bits    = ctrl1_reg;
  assign ctrl2_bits    = ctrl2_reg;

endmodule : dru_port

/* File: verif/dru_port_sva.sv */
// dru_port_sva: assertions on the pins of the ram update port
// assumes: bound to dru_port, sees its ports only
`timescale 1ns/1ps
module dru_port_sva
  import dru_pkg::*;
#(
  parameter int unsigned RAMP_STEP = 4
) (
  // system
  input wire logic               sys_clk,
  input wire logic               rst_n,
  // spi link
  input wire logic               spi_cs_n,
  input wire logic               spi_miso,
  input wire logic               spi_miso_oe_n,
  // core side
  input wire logic               core_halt,
  input wire logic [7:0]         volume_gain,
  input wire logic               boot_busy,
  input wire logic [CTRL1_W-1:0] ctrl1_bits,
  input wire logic [CTRL2_W-1:0] ctrl2_bits
);
  localparam int HALT_MAX = 300 * RAMP_STEP;
  logic [10:0] boot_cnt;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) boot_cnt <= 11'h000;
    else if (boot_cnt != 11'h7ff) boot_cnt <= boot_cnt + 11'h001;
  end

  // cycles since the shutdown request last changed, saturating
  logic        shut_q;
  int unsigned since_cnt;

  always_ff @(posedge sys_clk) begin
    shut_q <= ctrl1_bits[SHUTDOWN_BIT];
    if (!rst_n || shut_q != ctrl1_bits[SHUTDOWN_BIT]) since_cnt <= 0;
    else if (since_cnt <= HALT_MAX) since_cnt <= since_cnt + 1;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  boot_len_a: assert property ($fell(boot_busy) |-> boot_cnt inside {11'h400, 11'h401})
    else $error("boot ended at the wrong cycle");
  boot_hold_a: assert property (boot_cnt < 11'h3ff |-> boot_busy)
    else $error("boot ended early");
  halt_gain_a: assert property (core_halt |-> volume_gain == 8'h00)
    else $error("core halted with volume up");
  halt_cause_a: assert property ($rose(core_halt) |-> ctrl1_bits[SHUTDOWN_BIT])
    else $error("halt without request");
  ramp_step_a: assert property (!$stable(volume_gain) |->
    (volume_gain - $past(volume_gain)) inside {8'h01, 8'hff}) else $error("volume jumped");
  ramp_gap_a: assert property (!$stable(volume_gain) |=> $stable(volume_gain) [*3])
    else $error("volume steps too close");
  ramp_dir_a: assert property (!$stable(volume_gain) && ctrl1_bits[SHUTDOWN_BIT] ==
    $past(ctrl1_bits[SHUTDOWN_BIT], 2) |-> (volume_gain < $past(volume_gain)) ==
    ctrl1_bits[SHUTDOWN_BIT]) else $error("volume ramps the wrong way");
  halt_time_a: assert property (ctrl1_bits[SHUTDOWN_BIT] &&
    ctrl2_bits[RAMP_FAST_BIT] && since_cnt == HALT_MAX |-> core_halt)
    else $error("halt too late");
  resume_a: assert property (!ctrl1_bits[SHUTDOWN_BIT] &&
    ctrl2_bits[RAMP_FAST_BIT] && since_cnt == HALT_MAX |-> volume_gain == GAIN_MAX)
    else $error("volume not restored");
  idle_pins_a: assert property (spi_cs_n && $past(spi_cs_n) |-> spi_miso_oe_n && !spi_miso)
    else $error("miso driven outside a frame");
endmodule : dru_port_sva

bind dru_port dru_port_sva #(.RAMP_STEP(RAMP_STEP)) chk (.sys_clk, .rst_n, .spi_cs_n,
  .spi_miso, .spi_miso_oe_n, .core_halt, .volume_gain, .boot_busy, .ctrl1_bits, .ctrl2_bits);

/* File: verif/dru_host_model.sv */
// dru_host_model: spi host in mode 0 for the ram update port
// assumes: the bench asks for one frame at a time
`timescale 1ns/1ps
module dru_host_model (
  // spi link
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_clk = 1'b0;
    spi_mosi = 1'b0;
    // late edge so the frame logic surely sees its clear
    #1 spi_cs_n = 1'b1;
  end

  task automatic frame(input logic rd, input logic [9:0] adr, input int unsigned nb,
                       input logic [79:0] dout, output logic [79:0] din);
    logic [15:0] hdr;
    hdr = {5'b00000, rd, adr};
    din = '0;
    #7 spi_cs_n = 1'b0;
    for (int i = 0; i < 16 + nb; i++) begin
      spi_mosi = (i < 16) ? hdr[15-i] : dout[nb+15-i];
      #15 spi_clk = 1'b1;
      din = {din[78:0], spi_miso};
      #15 spi_clk = 1'b0;
    end
    #15 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask : frame
endmodule : dru_host_model

/* File: verif/dru_port_bench.sv */
// dru_port_bench: self-checking bench for the ram update port
// assumes: host model on the spi pins, bench plays the core
`timescale 1ns/1ps
module dru_port_bench;
  import dru_pkg::*;
  logic sys_clk, rst_n, core_param_busy, core_frame_start;
  logic [7:0] core_param_addr, volume_gain;
  logic [8:0] core_prog_addr;
  logic spi_clk, spi_cs_n, spi_mosi, spi_miso, core_halt, boot_busy;
  logic [PARAM_W-1:0] core_param_rdata;
  logic [PROG_W-1:0] core_prog_rdata;
  logic [CTRL1_W-1:0] ctrl1_bits;
  logic [CTRL2_W-1:0] ctrl2_bits;
  int errors, comparisons, n;
  string nq[$];
  logic [79:0] eq[$], gq[$];
  logic [79:0] rx, v0, v1, v2, g0, g1;

  dru_port #(.RAMP_STEP(4)) dut (.sys_clk, .rst_n, .spi_clk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe_n(), .core_param_addr, .core_param_busy, .core_prog_addr, .core_frame_start,
    .core_param_rdata, .core_prog_rdata, .core_halt, .volume_gain, .boot_busy, .ctrl1_bits,
    .ctrl2_bits);
  dru_host_model host (.spi_clk, .spi_cs_n, .spi_mosi, .spi_miso);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(string nm, logic [79:0] g, logic [79:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  initial forever begin
    wait (gq.size() > 0);
    check(nq.pop_front(), gq.pop_front(), eq.pop_front());
  end

  task automatic see(string nm, logic [79:0] g, logic [79:0] e);
    nq.push_back(nm);
    eq.push_back(e);
    gq.push_back(g);
  endtask : see

  task automatic wr(logic [9:0] a, int unsigned nb, logic [79:0] d);
    host.frame(1'b0, a, nb, d, rx);
  endtask : wr

  task automatic rd(logic [9:0] a, int unsigned nb, logic [79:0] e);
    host.frame(1'b1, a, nb, '0, rx);
    see("spi", rx & ((80'h1 << nb) - 80'h1), e);
  endtask : rd

  task automatic core(logic [7:0] a, logic [79:0] ea, logic [8:0] g, logic [79:0] eg);
    @(negedge sys_clk);
    core_param_addr = a;
    core_prog_addr = g;
    @(negedge sys_clk);
    see("core_param", 80'(core_param_rdata), ea);
    see("core_prog", 80'(core_prog_rdata), eg);
  endtask : core

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b1;
    #1 rst_n = 1'b0;
    core_param_busy = 1'b1;
    core_frame_start = 1'b0;
    core_param_addr = 8'h00;
    core_prog_addr = 9'h000;
    void'($urandom(32'h60cb_88c6));
    v0 = 80'($urandom) & 80'h3f_ffff;
    v1 = 80'($urandom) & 80'h3f_ffff;
    v2 = 80'($urandom) & 80'h3f_ffff;
    g0 = 80'({$urandom, $urandom}) & 80'h7_ffff_ffff;
    g1 = 80'({$urandom, $urandom}) & 80'h7_ffff_ffff;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    wr(10'h000, 24, v0);
    for (n = 0; n < 2000 && boot_busy !== 1'b0; n++) @(negedge sys_clk);
    see("boot_busy", 80'(boot_busy), 80'h0);
    see("ctrl1", 80'(ctrl1_bits), 80'(CTRL1_RST));
    see("ctrl2", 80'(ctrl2_bits), 80'(CTRL2_RST));
    core(8'h00, 80'h0, 9'h000, 80'h0);
    rd(CTRL2_ADDR, 16, 80'(CTRL2_RST));
    $display("test reset done");
    wr(CTRL1_ADDR, 16, 80'h0400);
    for (n = 0; n < 3000 && core_halt !== 1'b1; n++) @(negedge sys_clk);
    see("ramp_down", 80'(n * RAMP_TIME_MS >= 1024 * RAMP_MIN_MS &&
        n * RAMP_TIME_MS <= 1024 * RAMP_MAX_MS), 80'h1);
    rd(CTRL1_ADDR, 8, 80'h02);
    wr(10'h0fd, 72, {v0[23:0], v1[23:0], v2[23:0]});
    wr(10'h3fe, 80, {g0[39:0], g1[39:0]});
    rd(10'h0fd, 72, {v0[23:0], v1[23:0], v2[23:0]});
    rd(10'h3ff, 40, g1);
    core(8'hff, v2, 9'h1fe, g0);
    wr(10'h110, 24, v1);
    rd(10'h110, 24, 80'h0);
    wr(CTRL1_ADDR, 16, 80'h0000);
    for (n = 0; n < 3000 && volume_gain !== GAIN_MAX; n++) @(negedge sys_clk);
    see("ramp_up", 80'(n * RAMP_TIME_MS >= 1024 * RAMP_MIN_MS &&
        n * RAMP_TIME_MS <= 1024 * RAMP_MAX_MS), 80'h1);
    $display("test shutdown done");
    wr(10'h010, 24, v0);
    core(8'h10, v0, 9'h000, 80'h0);
    for (int k = 0; k < 5; k++) wr(SAFE_BASE + 10'(k), 32, {8'(8'h20 + k), 2'b00, 22'(v1 + k)});
    wr(CTRL1_ADDR, 16, 80'h1000);
    repeat (20) @(negedge sys_clk);
    core(8'h20, 80'h0, 9'h000, 80'h0);
    core_param_busy = 1'b0;
    repeat (8) @(negedge sys_clk);
    core_param_busy = 1'b1;
    for (int k = 0; k < 5; k++) core(8'(8'h20 + k), 80'(22'(v1 + k)), 9'h000, 80'h0);
    rd(CTRL1_ADDR, 8, 80'h01);
    rd(CTRL1_ADDR, 8, 80'h00);
    wr(10'h022, 24, v2);
    wr(SAFE_BASE, 32, {8'h20, v2[23:0]});
    wr(SAFE_BASE + 10'h004, 32, {8'h24, v0[23:0]});
    wr(CTRL1_ADDR, 16, 80'h1000);
    repeat (20) @(negedge sys_clk);
    core_frame_start = 1'b1;
    @(negedge sys_clk);
    core_frame_start = 1'b0;
    repeat (4) @(negedge sys_clk);
    core(8'h20, v2, 9'h000, 80'h0);
    core(8'h22, v2, 9'h000, 80'h0);
    core(8'h24, v0, 9'h000, 80'h0);
    rd(CTRL1_ADDR, 8, 80'h01);
    $display("test safe load done");
    wait (eq.size() == 0);
    tally_and_finish();
  end
endmodule : dru_port_bench
